// ===== pkg/rox_pkg.sv
// constants and types for the rotate-through-extend unit
// How it works
// - extend bit is one extra ring position
// - immediate count field zero means eight
// - register count taken modulo sixty-four
// - memory form: one bit, word size
// - size field selects byte, word, long
// - left: msb to carry/extend, extend in
// - right: lsb to carry/extend, extend in
// - extend gets last bit, kept on zero
// - negative from msb, zero flag, clear overflow
// - carry last bit, else copies extend
// - direction select: 0 right, 1 left
// - count source: 0 immediate, 1 register
// - register field picks rotated data register
// - memory form accepts memory-alterable modes only
package rox_pkg;
    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0]  OFF_OPCODE  = 8'h00;
    localparam logic [7:0]  OFF_OPERAND = 8'h04;
    localparam logic [7:0]  OFF_FLAGS   = 8'h08;
    localparam logic [7:0]  OFF_STATUS  = 8'h0C;
    localparam logic [7:0]  OFF_RESULT  = 8'h10;
    localparam logic [7:0]  OFF_DREG0   = 8'h20;
    localparam logic [7:0]  OFF_DREG7   = 8'h3C;
    // ==========================================================
    // flags register field positions
    localparam int FLAG_C = 0;
    localparam int FLAG_V = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 3;
    localparam int FLAG_X = 4;
    localparam logic [4:0]  FLAGS_RESET = 5'h00;
    // status register field positions
    localparam int STAT_BUSY    = 0;
    localparam int STAT_DONE    = 1;
    localparam int STAT_ILLEGAL = 2;
    // ==========================================================
    // opcode fields
    localparam logic [3:0]  REG_TOP     = 4'hE;
    localparam logic [1:0]  REG_TAG     = 2'h2;
    localparam logic [6:0]  MEM_TOP     = 7'h72;
    localparam logic [1:0]  MEM_SIZE    = 2'h3;
    localparam logic [1:0]  SIZE_BYTE   = 2'h0;
    localparam logic [1:0]  SIZE_WORD   = 2'h1;
    localparam logic [1:0]  SIZE_LONG   = 2'h2;
    localparam logic [2:0]  MODE_IND    = 3'h2;
    localparam logic [2:0]  MODE_INDEX  = 3'h6;
    localparam logic [2:0]  MODE_ABS    = 3'h7;
    localparam logic [2:0]  ABS_LONG    = 3'h1;
    localparam logic [6:0]  IMM_ZERO_COUNT = 7'h08;
    localparam logic [6:0]  MEM_COUNT      = 7'h01;
    localparam logic [31:0] DREG_RESET     = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01
    } state_e;
endpackage : rox_pkg

// ===== rtl/rotate_through_extend_unit.sv
// rotate-through-extend execution unit with an AHB-Lite register slave
`timescale 1ns/10ps
module rotate_through_extend_unit
    import rox_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata
);
    // ==========================================================
    // bus address phase capture
    logic        wrPhase_reg;
    logic        rdPhase_reg;
    logic [7:0]  addr_reg;
    logic        accept;

    assign accept    = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wrPhase_reg <= 1'b0;
            rdPhase_reg <= 1'b0;
            addr_reg    <= 8'h00;
        end else begin
            wrPhase_reg <= accept && hwrite;
            rdPhase_reg <= accept && !hwrite;
            if (accept) begin
                addr_reg <= {haddr[7:2], 2'b00};
            end
        end
    end

    // ==========================================================
    // state and working registers
    state_e      state_reg;
    logic [31:0] dreg [8];
    logic [15:0] operand_reg;
    logic [15:0] result_reg;
    logic [4:0]  flags_reg;
    logic        done_reg;
    logic        illegal_reg;
    logic [31:0] work_reg;
    logic        xWork_reg;
    logic [6:0]  count_reg;
    logic [1:0]  size_reg;
    logic        left_reg;
    logic        memForm_reg;
    logic [2:0]  dst_reg;
    logic        zeroCount_reg;
    logic [4:0]  xAtStart_reg;

    // ==========================================================
    // opcode decode of the word being written
    logic [15:0] op;
    logic        isRegForm;
    logic        isMemForm;
    logic        eaOk;
    logic        opWrite;
    logic        start;
    logic        reject;
    logic [6:0]  startCount;
    logic [1:0]  startSize;
    logic [31:0] startWork;
    logic        busy;

    assign op   = hwdata[15:0];
    assign busy = (state_reg == ST_RUN);
    assign isRegForm = (op[15:12] == REG_TOP) && (op[4:3] == REG_TAG)
                       && (op[7:6] != MEM_SIZE);
    assign isMemForm = (op[15:9] == MEM_TOP) && (op[7:6] == MEM_SIZE);
    // memory-alterable only: no data/address direct, no pc-relative, no immediate
    assign eaOk = ((op[5:3] >= MODE_IND) && (op[5:3] <= MODE_INDEX))
                  || ((op[5:3] == MODE_ABS) && (op[2:0] <= ABS_LONG));
    assign opWrite = wrPhase_reg && (addr_reg == OFF_OPCODE);
    assign start   = opWrite && !busy && (isRegForm || (isMemForm && eaOk));
    assign reject  = opWrite && !busy && !(isRegForm || (isMemForm && eaOk));

    always_comb begin
        startSize  = SIZE_WORD;
        startCount = MEM_COUNT;
        startWork  = {16'h0000, operand_reg};
        if (isRegForm) begin
            startSize = op[7:6];
            startWork = dreg[op[2:0]];
            if (op[5]) begin
                startCount = {1'b0, dreg[op[11:9]][5:0]};
            end else if (op[11:9] == 3'h0) begin
                startCount = IMM_ZERO_COUNT;
            end else begin
                startCount = {4'h0, op[11:9]};
            end
        end
    end

    // ==========================================================
    // rotation step
    logic [31:0] stepVal;
    logic        stepX;
    logic        stepping;
    logic        commit;
    logic [31:0] sizedRes;
    logic        resNeg;
    logic        resZero;

    assign stepping = busy && (count_reg != 7'h00);
    assign commit   = busy && (count_reg == 7'h00);

    rox_step u_step (
        .val     (work_reg),
        .sizeSel (size_reg),
        .rotLeft (left_reg),
        .xIn     (xWork_reg),
        .valNext (stepVal),
        .xNext   (stepX)
    );

    always_comb begin
        case (size_reg)
            SIZE_BYTE: sizedRes = {24'h0, work_reg[7:0]};
            SIZE_WORD: sizedRes = {16'h0, work_reg[15:0]};
            default:   sizedRes = work_reg;
        endcase
    end
    assign resZero = (sizedRes == 32'h0000_0000);
    assign resNeg  = (size_reg == SIZE_BYTE) ? work_reg[7] :
                     (size_reg == SIZE_WORD) ? work_reg[15] : work_reg[31];

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: if (start) state_reg <= ST_RUN;
                ST_RUN:  if (commit) state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            work_reg      <= DREG_RESET;
            xWork_reg     <= 1'b0;
            count_reg     <= 7'h00;
            size_reg      <= SIZE_BYTE;
            left_reg      <= 1'b0;
            memForm_reg   <= 1'b0;
            dst_reg       <= 3'h0;
            zeroCount_reg <= 1'b0;
            xAtStart_reg  <= FLAGS_RESET;
        end else if (start) begin
            work_reg      <= startWork;
            xWork_reg     <= flags_reg[FLAG_X];
            count_reg     <= startCount;
            size_reg      <= startSize;
            left_reg      <= op[8];
            memForm_reg   <= isMemForm;
            dst_reg       <= op[2:0];
            zeroCount_reg <= (startCount == 7'h00);
            xAtStart_reg  <= flags_reg;
        end else if (stepping) begin
            work_reg  <= stepVal;
            xWork_reg <= stepX;
            count_reg <= count_reg - 7'h01;
        end
    end

    // ==========================================================
    // architectural state: data registers, flags, results
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 8; i++) begin
                dreg[i] <= DREG_RESET;
            end
        end else if (commit && !memForm_reg) begin
            dreg[dst_reg] <= work_reg;
        end else if (wrPhase_reg && !busy && addr_reg >= OFF_DREG0
                     && addr_reg <= OFF_DREG7) begin
            dreg[addr_reg[4:2]] <= hwdata;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            flags_reg <= FLAGS_RESET;
        end else if (commit) begin
            flags_reg[FLAG_X] <= xWork_reg;
            flags_reg[FLAG_N] <= resNeg;
            flags_reg[FLAG_Z] <= resZero;
            flags_reg[FLAG_V] <= 1'b0;
            flags_reg[FLAG_C] <= xWork_reg;
        end else if (wrPhase_reg && !busy && addr_reg == OFF_FLAGS) begin
            flags_reg <= hwdata[4:0];
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            operand_reg <= 16'h0000;
            result_reg  <= 16'h0000;
        end else begin
            if (wrPhase_reg && !busy && addr_reg == OFF_OPERAND) begin
                operand_reg <= hwdata[15:0];
            end
            if (commit && memForm_reg) begin
                result_reg <= work_reg[15:0];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            done_reg    <= 1'b0;
            illegal_reg <= 1'b0;
        end else begin
            if (commit) begin
                done_reg <= 1'b1;
            end else if (start || reject) begin
                done_reg <= 1'b0;
            end
            if (reject) begin
                illegal_reg <= 1'b1;
            end else if (start) begin
                illegal_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // read data
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            hrdata <= 32'h0000_0000;
        end else if (accept && !hwrite) begin
            case ({haddr[7:2], 2'b00})
                OFF_OPCODE:  hrdata <= 32'h0000_0000;
                OFF_OPERAND: hrdata <= {16'h0000, operand_reg};
                OFF_FLAGS:   hrdata <= {27'h0, flags_reg};
                OFF_STATUS:  hrdata <= {29'h0, illegal_reg, done_reg, busy};
                OFF_RESULT:  hrdata <= {16'h0000, result_reg};
                default: begin
                    if (haddr[7:0] >= OFF_DREG0 && haddr[7:0] <= OFF_DREG7 + 8'h3) begin
                        hrdata <= dreg[haddr[4:2]];
                    end else begin
                        hrdata <= 32'h0000_0000;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // assertions
    property p_imm_zero;
        @(posedge sys_clk) disable iff (reset)
        start && isRegForm && !op[5] && op[11:9] == 3'h0 |=> count_reg == 7'h08;
    endproperty
    a_imm_zero: assert property (p_imm_zero) else $error("zero immediate not eight");

    property p_reg_count;
        @(posedge sys_clk) disable iff (reset)
        start && isRegForm && op[5] |=> count_reg == {1'b0, $past(dreg[op[11:9]][5:0])};
    endproperty
    a_reg_count: assert property (p_reg_count) else $error("count above 63");

    property p_mem_form;
        @(posedge sys_clk) disable iff (reset)
        start && isMemForm |=> count_reg == 7'h01 && size_reg == SIZE_WORD ##2 !busy;
    endproperty
    a_mem_form: assert property (p_mem_form) else $error("memory form not one word bit");

    property p_zero_keeps_x;
        @(posedge sys_clk) disable iff (reset)
        commit && zeroCount_reg |=> flags_reg[FLAG_X] == xAtStart_reg[FLAG_X]
                                    && flags_reg[FLAG_C] == xAtStart_reg[FLAG_X];
    endproperty
    a_zero_keeps_x: assert property (p_zero_keeps_x) else $error("zero count moved x");

    property p_v_clear;
        @(posedge sys_clk) disable iff (reset)
        commit |=> !flags_reg[FLAG_V] && flags_reg[FLAG_Z] == $past(resZero);
    endproperty
    a_v_clear: assert property (p_v_clear) else $error("overflow or zero wrong");

    property p_c_is_x;
        @(posedge sys_clk) disable iff (reset)
        commit |=> flags_reg[FLAG_C] == flags_reg[FLAG_X];
    endproperty
    a_c_is_x: assert property (p_c_is_x) else $error("carry differs from extend");

    property p_left_out;
        @(posedge sys_clk) disable iff (reset)
        stepping && left_reg |=> xWork_reg == $past(resNeg);
    endproperty
    a_left_out: assert property (p_left_out) else $error("left out bit not msb");

    property p_right_out;
        @(posedge sys_clk) disable iff (reset)
        stepping && !left_reg |=> xWork_reg == $past(work_reg[0]);
    endproperty
    a_right_out: assert property (p_right_out) else $error("right out bit not lsb");

    property p_reject_dn;
        @(posedge sys_clk) disable iff (reset)
        opWrite && !busy && isMemForm && op[5:3] == 3'h0 |=> illegal_reg && !busy;
    endproperty
    a_reject_dn: assert property (p_reject_dn) else $error("direct mode accepted");

    property p_zero_keeps_reg;
        @(posedge sys_clk) disable iff (reset)
        start && isRegForm && startCount == 7'h00 |=> ##1 dreg[dst_reg] == $past(startWork, 2);
    endproperty
    a_zero_keeps_reg: assert property (p_zero_keeps_reg) else $error("zero count changed reg");

    c_left_reg:  cover property (@(posedge sys_clk) start && isRegForm && op[8]);
    c_right_mem: cover property (@(posedge sys_clk) start && isMemForm && !op[8]);
    c_reject:    cover property (@(posedge sys_clk) reject);
    c_zero_cnt:  cover property (@(posedge sys_clk) commit && zeroCount_reg);
endmodule : rotate_through_extend_unit

// ===== rtl/rox_step.sv
// one bit position of rotation through the extend flag
`timescale 1ns/10ps
module rox_step
    import rox_pkg::*;
(
    input  wire logic [31:0] val,
    input  wire logic [1:0]  sizeSel,
    input  wire logic        rotLeft,
    input  wire logic        xIn,
    output logic      [31:0] valNext,
    output logic             xNext
);
    always_comb begin
        valNext = val;
        xNext   = xIn;
        // bits above the sized operand are kept
        case (sizeSel)
            SIZE_BYTE: begin
                if (rotLeft) begin
                    xNext   = val[7];
                    valNext = {val[31:8], val[6:0], xIn};
                end else begin
                    xNext   = val[0];
                    valNext = {val[31:8], xIn, val[7:1]};
                end
            end
            SIZE_WORD: begin
                if (rotLeft) begin
                    xNext   = val[15];
                    valNext = {val[31:16], val[14:0], xIn};
                end else begin
                    xNext   = val[0];
                    valNext = {val[31:16], xIn, val[15:1]};
                end
            end
            default: begin
                if (rotLeft) begin
                    xNext   = val[31];
                    valNext = {val[30:0], xIn};
                end else begin
                    xNext   = val[0];
                    valNext = {xIn, val[31:1]};
                end
            end
        endcase
    end
endmodule : rox_step

// ===== verif/test_rotate_through_extend_unit.sv
// self-checking testbench for the rotate-through-extend unit
`timescale 1ns/10ps
module test_rotate_through_extend_unit
    import rox_pkg::*;
;
    // ==========================================================
    // signals and design instance
    logic        sys_clk;
    logic        reset;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    wire logic   hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    int          error_cnt;
    int          comparisons;
    logic [31:0] got;

    always #5 sys_clk = ~sys_clk;

    rotate_through_extend_unit uut (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hreadyout),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata)
    );

    // ==========================================================
    // checking and bus tasks
    task automatic close_out;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // entered just after a rising edge; single word transfer
    task automatic xfer(input logic [7:0] addr, input logic wr, input logic [31:0] wdata,
                        output logic [31:0] rdata);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, addr};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdata;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rdata = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask : xfer

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] unused;
        xfer(addr, 1'b1, data, unused);
    endtask : wr

    task automatic rd(input logic [7:0] addr, output logic [31:0] data);
        xfer(addr, 1'b0, 32'h0, data);
    endtask : rd

    task automatic waitDone(output logic [31:0] st);
        st = 32'h1;
        for (int i = 0; i < 200 && st[0] !== 1'b0; i++) begin
            rd(OFF_STATUS, st);
        end
    endtask : waitDone

    // ==========================================================
    // reference model: ring of sized operand plus extend bit
    function automatic int widthOf(input logic [1:0] sz);
        return (sz == 2'h0) ? 8 : (sz == 2'h1) ? 16 : 32;
    endfunction : widthOf

    function automatic logic [32:0] model(input logic [31:0] v, input int w, input logic left,
                                          input int n, input logic x);
        logic nx;
        for (int i = 0; i < n; i++) begin
            nx = left ? v[w-1] : v[0];
            if (left) begin
                for (int j = w - 1; j > 0; j--) v[j] = v[j-1];
                v[0] = x;
            end else begin
                for (int j = 0; j < w - 1; j++) v[j] = v[j+1];
                v[w-1] = x;
            end
            x = nx;
        end
        return {x, v};
    endfunction : model

    function automatic logic [31:0] flagsOf(input logic [32:0] m, input int w);
        return {27'h0, m[32], m[w-1], (m[31:0] << (32 - w)) == 32'h0, 1'b0, m[32]};
    endfunction : flagsOf

    function automatic logic [7:0] dregAddr(input logic [2:0] rn);
        return OFF_DREG0 + {3'h0, rn, 2'h0};
    endfunction : dregAddr

    // ==========================================================
    // scenario tasks
    task automatic runReg(input logic [1:0] sz, input logic dr, input logic ir,
                          input logic [2:0] cf, input logic [2:0] rn, input logic [31:0] v,
                          input logic x, input logic [31:0] cnt, input logic poke);
        logic [32:0] m;
        logic [31:0] st;
        int          n;
        n = ir ? int'(cnt % 64) : ((cf == 3'h0) ? 8 : int'(cf));
        m = model(v, widthOf(sz), dr, n, x);
        if (ir) wr(dregAddr(cf), cnt);
        wr(dregAddr(rn), v);
        wr(OFF_FLAGS, {27'h0, x, 4'hF});
        wr(OFF_OPCODE, {16'h0, 4'hE, cf, dr, sz, ir, 2'h2, rn});
        if (poke) wr(dregAddr(rn), 32'hFFFF_FFFF);
        waitDone(st);
        check(st & 32'h3, 32'h2);
        rd(dregAddr(rn), got);
        check(got, m[31:0]);
        rd(OFF_FLAGS, got);
        check(got, flagsOf(m, widthOf(sz)));
    endtask : runReg

    task automatic runMem(input logic dr, input logic [5:0] ea, input logic [31:0] v,
                          input logic x);
        logic [32:0] m;
        logic [31:0] st;
        m = model({16'h0, v[15:0]}, 16, dr, 1, x);
        wr(OFF_OPERAND, v);
        wr(OFF_FLAGS, {27'h0, x, 4'hF});
        wr(OFF_OPCODE, {16'h0, 7'h72, dr, 2'h3, ea});
        waitDone(st);
        check(st & 32'h3, 32'h2);
        rd(OFF_RESULT, got);
        check(got, {16'h0, m[15:0]});
        rd(OFF_FLAGS, got);
        check(got, flagsOf(m, 16));
    endtask : runMem

    task automatic runIllegal(input logic [15:0] op);
        logic [31:0] st;
        wr(OFF_OPCODE, {16'h0, op});
        waitDone(st);
        check(st & 32'h7, 32'h4);
    endtask : runIllegal

    // ==========================================================
    // main sequence and watchdog
    logic [5:0] goodEa [7] = '{6'h11, 6'h1A, 6'h23, 6'h2C, 6'h35, 6'h38, 6'h39};
    logic [5:0] badEa  [5] = '{6'h00, 6'h0A, 6'h3A, 6'h3B, 6'h3C};

    initial begin
        sys_clk     = 1'b0;
        reset       = 1'b1;
        hsel        = 1'b0;
        haddr       = 32'h0;
        htrans      = 2'h0;
        hwrite      = 1'b0;
        hsize       = 3'h2;
        hwdata      = 32'h0;
        error_cnt   = 0;
        comparisons = 0;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        rd(OFF_FLAGS, got);
        check(got, 32'h0);
        rd(OFF_STATUS, got);
        check(got, 32'h0);
        rd(OFF_DREG7, got);
        check(got, 32'h0);
        for (int i = 0; i < 12; i++) begin
            runReg(2'(i / 4), i[0], 1'b0, i[1] ? 3'h0 : 3'(i % 7 + 1), 3'(i % 8),
                   32'h8F3C_5A61 + 32'(i) * 32'h1357_9BDF, i[2], 32'h0, 1'b0);
        end
        runReg(SIZE_LONG, 1'b1, 1'b1, 3'h5, 3'h2, 32'h8000_0001, 1'b1, 32'h41, 1'b0);
        runReg(SIZE_BYTE, 1'b0, 1'b1, 3'h6, 3'h3, 32'h0000_0080, 1'b1, 32'h40, 1'b0);
        runReg(SIZE_BYTE, 1'b1, 1'b1, 3'h6, 3'h1, 32'h1234_5600, 1'b0, 32'h80, 1'b0);
        runReg(SIZE_WORD, 1'b0, 1'b1, 3'h1, 3'h4, 32'h0000_007F, 1'b0, 32'h3F, 1'b0);
        runReg(SIZE_LONG, 1'b1, 1'b0, 3'h0, 3'h6, 32'h0123_4567, 1'b0, 32'h0, 1'b1);
        for (int i = 0; i < 7; i++) begin
            runMem(i[0], goodEa[i], 32'h5A5A_8001 + 32'(i) * 32'h0001_1111, i[1]);
        end
        for (int i = 0; i < 5; i++) begin
            runIllegal({7'h72, i[0], 2'h3, badEa[i]});
        end
        runIllegal({4'hE, 3'h1, 1'b0, 2'h3, 1'b0, 2'h2, 3'h0});
        wr(8'h80, 32'hDEAD_BEEF);
        rd(8'h80, got);
        check(got, 32'h0);
        close_out();
    end

    initial begin
        #200000;
        error_cnt++;
        close_out();
    end
endmodule : test_rotate_through_extend_unit
